/* core/pwm_regs.vh */
// constants for the pwm fault protection control block
// assumes a 32-bit apb master; each register sits in one aligned word
// How it works
// - with limit enabled, delay writes above the limit are dropped
// - eight enable bits gate the eight error inputs
// - input 0 is phase protect, inputs 1..7 are comparators 2..8
// - action code: stop now, stop at period end, shrink-then-stop, shrink
// - codes of inputs 0..3 in action_lo, inputs 4..7 in action_hi
// - active flag is OR of enabled sources, clears when they vanish
// - action fields cannot be written while the active flag is set
// - soft trigger flag bit 5 is set by hardware, only cleared by software
// - bit 4 of status_soft enables the software error bit
// - bits 1..0 of status_soft hold the software error action code
// - polarity bit 0 inverts channels 0 and 2, bit 1 channels 1 and 3
// - buffered 12-bit period; frequency is clock over period plus one
// - live 12-bit counter readable, writes there do nothing
// - channel 0/2 dead time is a buffered 12-bit value
// - unimplemented upper bits read zero, all bits reset to zero
// - dead time lasts value plus one cycles, capped at the duty
// - software error bit acts only while its enable is set
// - run rising clears the counter, falling holds it
`ifndef PWM_FAULT_REGS_VH
`define PWM_FAULT_REGS_VH

`define OFS_ERR_ENABLE     8'h00
`define OFS_ACTION_LO      8'h04
`define OFS_ACTION_HI      8'h08
`define OFS_STATUS_SOFT    8'h0c
`define OFS_POLARITY       8'h10
`define OFS_PERIOD_LOW     8'h14
`define OFS_PERIOD_HIGH    8'h18
`define OFS_DUTY_LOW       8'h1c
`define OFS_DUTY_HIGH      8'h20
`define OFS_COUNTER_LOW    8'h24
`define OFS_COUNTER_HIGH   8'h28
`define OFS_DEADTIME_LOW   8'h2c
`define OFS_DEADTIME_HIGH  8'h30
`define OFS_CONTROL        8'h34
`define OFS_DELAY          8'h38
`define OFS_DELAY_LIMIT    8'h3c
`define OFS_MIN_PERIOD     8'h40

`define BIT_ACTIVE_FLAG    7
`define BIT_SOFT_FLAG      5
`define BIT_SOFT_ENABLE    4
`define BIT_RUN            0
`define BIT_LIMIT_ENABLE   1
`define BIT_SOFT_ERROR     2

`define ACT_STOP_NOW       2'b00
`define ACT_STOP_END       2'b01
`define ACT_SHRINK_STOP    2'b10
`define ACT_SHRINK_ONLY    2'b11

`endif

/* core/pwm_fault_protection_control.v */
// pwm generator core with error protection, polarity and buffered timing
// assumes apb master on the pwm clock; error inputs already synchronous
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"

module pwm_fault_protection_control
#(
  parameter [11:0] shrink_step = 12'h001
)
(
  input  wire        clock,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        phase_protect_out,
  input  wire [6:0]  overvolt_comp_out,
  output reg  [3:0]  pwm_out,
  output reg         pwm_shutdown
);

  reg  [7:0]  error_source_enable;
  reg  [7:0]  protection_action_lo;
  reg  [7:0]  protection_action_hi;
  reg         soft_trigger_flag;
  reg         soft_trigger_enable;
  reg  [1:0]  soft_action;
  reg         protection_active_flag;
  reg  [1:0]  output_polarity;
  reg  [11:0] period_value;
  reg  [11:0] duty_value;
  reg  [11:0] deadtime_a_value;
  reg         run_control;
  reg         delay_limit_enable;
  reg         software_error_bit;
  reg  [10:0] output_delay_value;
  reg  [10:0] delay_limit;
  reg  [11:0] minimum_period;
  reg  [11:0] counter;
  reg  [11:0] act_period;
  reg  [11:0] act_duty;
  reg  [11:0] act_deadtime;
  reg         run_prev;
  reg         stop_pending;
  reg         soft_prev;

  wire [7:0]  error_input;
  wire [7:0]  err_live;
  wire        soft_live;
  wire        any_live;
  wire        wr_en;
  wire        rd_setup;
  wire        boundary;
  wire        adjusting;
  reg         want_now;
  reg         want_end;
  reg         want_shrink_stop;
  reg         want_shrink;
  reg  [31:0] next_prdata;
  reg         next_err;
  reg  [3:0]  next_pwm;
  integer     i;

  // unpacks the code of one source from the two action registers
  function [1:0] action_of;
    input [2:0] idx;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (idx[2])
        action_of = hi[{idx[1:0], 1'b0} +: 2];
      else
        action_of = lo[{idx[1:0], 1'b0} +: 2];
    end
  endfunction

  // zero-extends a narrow field into a bus word
  function [31:0] word12;
    input [11:0] v;
    begin
      word12 = {20'h00000, v};
    end
  endfunction

  // comparators 2..8 sit above the phase input in the error vector
  assign error_input = {overvolt_comp_out, phase_protect_out};
  assign err_live    = error_input & error_source_enable;
  assign soft_live   = software_error_bit & soft_trigger_enable;
  assign any_live    = (|err_live) | soft_live;
  assign wr_en       = psel & penable & pwrite;
  assign rd_setup    = psel & ~penable & ~pwrite;
  assign boundary    = (counter >= act_period);
  assign adjusting   = want_shrink | want_shrink_stop;

  // collect the actions demanded by every live source
  // several may be live at once and the harshest one decides the stop
  always @*
  begin
    want_now = 1'b0;
    want_end = 1'b0;
    want_shrink_stop = 1'b0;
    want_shrink = 1'b0;
    for (i = 0; i < 9; i = i + 1)
    begin
      if ((i < 8) ? err_live[i] : soft_live)
      begin
        case ((i < 8) ? action_of(i[2:0], protection_action_lo,
                                  protection_action_hi) : soft_action)
          `ACT_STOP_NOW:    want_now = 1'b1;
          `ACT_STOP_END:    want_end = 1'b1;
          `ACT_SHRINK_STOP: want_shrink_stop = 1'b1;
          `ACT_SHRINK_ONLY: want_shrink = 1'b1;
          default:          want_now = 1'b1;
        endcase
      end
    end
  end

  // read mux and unmapped-address decode
  always @*
  begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `OFS_ERR_ENABLE:    next_prdata = {24'h000000, error_source_enable};
      `OFS_ACTION_LO:     next_prdata = {24'h000000, protection_action_lo};
      `OFS_ACTION_HI:     next_prdata = {24'h000000, protection_action_hi};
      `OFS_STATUS_SOFT:   next_prdata = {24'h000000, protection_active_flag,
                                         1'b0, soft_trigger_flag,
                                         soft_trigger_enable, 2'b00,
                                         soft_action};
      `OFS_POLARITY:      next_prdata = {30'h0, output_polarity};
      `OFS_PERIOD_LOW:    next_prdata = {24'h000000, period_value[7:0]};
      `OFS_PERIOD_HIGH:   next_prdata = {28'h0000000, period_value[11:8]};
      `OFS_DUTY_LOW:      next_prdata = {24'h000000, duty_value[7:0]};
      `OFS_DUTY_HIGH:     next_prdata = {28'h0000000, duty_value[11:8]};
      `OFS_COUNTER_LOW:   next_prdata = {24'h000000, counter[7:0]};
      `OFS_COUNTER_HIGH:  next_prdata = {28'h0000000, counter[11:8]};
      `OFS_DEADTIME_LOW:  next_prdata = {24'h000000, deadtime_a_value[7:0]};
      `OFS_DEADTIME_HIGH: next_prdata = {28'h0000000, deadtime_a_value[11:8]};
      `OFS_CONTROL:       next_prdata = {29'h0, software_error_bit,
                                         delay_limit_enable, run_control};
      `OFS_DELAY:         next_prdata = {21'h0, output_delay_value};
      `OFS_DELAY_LIMIT:   next_prdata = {21'h0, delay_limit};
      `OFS_MIN_PERIOD:    next_prdata = word12(minimum_period);
      default:            next_err = 1'b1;
    endcase
  end

  // apb answers with no wait state; read data is captured in setup
  // pready only drops in reset, so a master never waits on this block
  always @(posedge clock)
  begin
    if (srst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (rd_setup)
        prdata <= next_prdata;
      if (psel & ~penable)
        pslverr <= next_err;
    end
  end

  // software-visible registers
  // a locked action code cannot be softened by software while its fault
  // is still being handled
  always @(posedge clock)
  begin
    if (srst)
    begin
      error_source_enable  <= 8'h00;
      protection_action_lo <= 8'h00;
      protection_action_hi <= 8'h00;
      soft_trigger_enable  <= 1'b0;
      soft_action          <= 2'b00;
      output_polarity      <= 2'b00;
      period_value         <= 12'h000;
      duty_value           <= 12'h000;
      deadtime_a_value     <= 12'h000;
      run_control          <= 1'b0;
      delay_limit_enable   <= 1'b0;
      software_error_bit   <= 1'b0;
      output_delay_value   <= 11'h000;
      delay_limit          <= 11'h000;
      minimum_period       <= 12'h000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_ERR_ENABLE: error_source_enable <= pwdata[7:0];
        `OFS_ACTION_LO:
          if (!protection_active_flag)
            protection_action_lo <= pwdata[7:0];
        `OFS_ACTION_HI:
          if (!protection_active_flag)
            protection_action_hi <= pwdata[7:0];
        `OFS_STATUS_SOFT:
        begin
          soft_trigger_enable <= pwdata[`BIT_SOFT_ENABLE];
          if (!protection_active_flag)
            soft_action <= pwdata[1:0];
        end
        `OFS_POLARITY:      output_polarity <= pwdata[1:0];
        `OFS_PERIOD_LOW:    period_value[7:0] <= pwdata[7:0];
        `OFS_PERIOD_HIGH:   period_value[11:8] <= pwdata[3:0];
        `OFS_DUTY_LOW:      duty_value[7:0] <= pwdata[7:0];
        `OFS_DUTY_HIGH:     duty_value[11:8] <= pwdata[3:0];
        `OFS_DEADTIME_LOW:  deadtime_a_value[7:0] <= pwdata[7:0];
        `OFS_DEADTIME_HIGH: deadtime_a_value[11:8] <= pwdata[3:0];
        `OFS_CONTROL:
        begin
          run_control        <= pwdata[`BIT_RUN];
          delay_limit_enable <= pwdata[`BIT_LIMIT_ENABLE];
          software_error_bit <= pwdata[`BIT_SOFT_ERROR];
        end
        // the limit only guards new writes; a larger stored value stays
        `OFS_DELAY:
          if (!delay_limit_enable || pwdata[10:0] <= delay_limit)
            output_delay_value <= pwdata[10:0];
        `OFS_DELAY_LIMIT:   delay_limit <= pwdata[10:0];
        `OFS_MIN_PERIOD:    minimum_period <= pwdata[11:0];
        default:            minimum_period <= minimum_period;
      endcase
    end
  end

  // protection flags; the hardware set wins over a software clear
  // the active flag trails its sources by one cycle
  always @(posedge clock)
  begin
    if (srst)
    begin
      protection_active_flag <= 1'b0;
      soft_trigger_flag      <= 1'b0;
      soft_prev              <= 1'b0;
    end
    else
    begin
      protection_active_flag <= any_live;
      soft_prev <= soft_live;
      if (soft_live & ~soft_prev)
        soft_trigger_flag <= 1'b1;
      else if (wr_en && paddr == `OFS_STATUS_SOFT &&
               !pwdata[`BIT_SOFT_FLAG])
        soft_trigger_flag <= 1'b0;
    end
  end

  // counter, shadow loading and protection-driven shutdown
  // stop reasons latch until run_control rises again, so a fault that
  // clears by itself never restarts the bridge unasked
  always @(posedge clock)
  begin
    if (srst)
    begin
      counter      <= 12'h000;
      act_period   <= 12'h000;
      act_duty     <= 12'h000;
      act_deadtime <= 12'h000;
      run_prev     <= 1'b0;
      stop_pending <= 1'b0;
      pwm_shutdown <= 1'b0;
    end
    else
    begin
      run_prev <= run_control;
      if (run_control & ~run_prev)
      begin
        counter      <= 12'h000;
        act_period   <= period_value;
        act_duty     <= duty_value;
        act_deadtime <= deadtime_a_value;
        stop_pending <= 1'b0;
        pwm_shutdown <= 1'b0;
      end
      else if (run_control && !pwm_shutdown)
      begin
        if (want_now)
          pwm_shutdown <= 1'b1;
        if (want_end)
          stop_pending <= 1'b1;
        if (boundary)
        begin
          counter <= 12'h000;
          if (stop_pending | want_end)
            pwm_shutdown <= 1'b1;
          else if (want_shrink_stop && act_period < minimum_period)
            pwm_shutdown <= 1'b1;
          // shrinking stops at the floor so the count never wraps
          if (adjusting && act_period > shrink_step)
            act_period <= act_period - shrink_step;
          else if (!adjusting)
            act_period <= period_value;
          // shadows move only here and at run start, so no period mixes old and new values
          act_duty     <= duty_value;
          act_deadtime <= deadtime_a_value;
        end
        else
          counter <= counter + 12'h001;
      end
    end
  end

  // complementary outputs; channel 0/2 waits out the dead time first
  // a stop-now demand darkens the outputs at once, on the same edge
  // that sets pwm_shutdown itself
  always @*
  begin
    next_pwm = 4'h0;
    if (run_control && !pwm_shutdown && !want_now)
    begin
      next_pwm[0] = (counter < act_duty) &&
                    (counter > ((act_deadtime > act_duty) ?
                                act_duty : act_deadtime));
      next_pwm[1] = (counter >= act_duty);
      next_pwm[2] = next_pwm[0];
      next_pwm[3] = next_pwm[1];
      next_pwm = next_pwm ^ {output_polarity[1], output_polarity[0],
                             output_polarity[1], output_polarity[0]};
    end
  end

  // registered so the bridge never sees a combinational glitch
  always @(posedge clock)
  begin
    if (srst)
      pwm_out <= 4'h0;
    else
      pwm_out <= next_pwm;
  end

endmodule
`default_nettype wire

/* verif/pwm_fault_protection_control_props.sv */
// assertions on the pwm fault protection ports
// assumes one clock and the zero-wait apb slave timing
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"
module pwm_fault_checker
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        phase_protect_out,
  input wire logic [6:0]  overvolt_comp_out,
  input wire logic [3:0]  pwm_out,
  input wire logic        pwm_shutdown
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic      run;
  wire logic acc = psel && penable && pready;
  wire logic rd = acc && !pwrite;
  wire logic ctl = acc && pwrite && paddr == `OFS_CONTROL;
  // run is only visible through bus writes, so mirror it here
  always_ff @(posedge clock)
    if (srst)
      run <= 1'b0;
    else if (ctl)
      run <= pwdata[`BIT_RUN];
  chk_quiet_reset: assert property
    ($fell(srst) |-> pwm_out == 4'h0 && !pwm_shutdown)
    else $error("outputs busy after reset");
  chk_ch_pairs: assert property
    (pwm_out[0] == pwm_out[2] && pwm_out[1] == pwm_out[3])
    else $error("paired channels differ");
  chk_stop_dark: assert property
    (pwm_shutdown && $past(pwm_shutdown) |-> pwm_out == 4'h0)
    else $error("outputs on while stopped");
  chk_stop_latched: assert property
    (pwm_shutdown && !run && !ctl |=> pwm_shutdown)
    else $error("stop released without run");
  chk_halt_dark: assert property
    (!run && !$past(run) |-> pwm_out == 4'h0)
    else $error("outputs on while halted");
  chk_zero_wait: assert property
    (psel && !penable |=> pready)
    else $error("access phase not ready");
  chk_status_gaps: assert property
    (rd && paddr == `OFS_STATUS_SOFT |->
      prdata[31:8] == 24'h0 && !prdata[6] && prdata[3:2] == 2'h0)
    else $error("status gaps not zero");
  chk_counter_top: assert property
    (rd && paddr == `OFS_COUNTER_HIGH |-> prdata[31:4] == 28'h0)
    else $error("counter top bits set");
endmodule
bind pwm_fault_protection_control pwm_fault_checker chk_u
(
  .clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
  .phase_protect_out(phase_protect_out), .pwm_shutdown(pwm_shutdown),
  .overvolt_comp_out(overvolt_comp_out)
);
`default_nettype wire

/* verif/pwm_power_stage.sv */
// comparator and phase detector front end of the power stage
// assumes trips are requested by the bench on the pwm clock
`timescale 1ns/1ps
`default_nettype none
module pwm_power_stage
(
  input  wire logic       clock,
  input  wire logic       trip_phase,
  input  wire logic [6:0] trip_comp,
  output var  logic       phase_protect_out,
  output var  logic [6:0] overvolt_comp_out
);
  // registered, so a trip never lands on the design's sampling edge
  always_ff @(posedge clock)
  begin
    phase_protect_out <= trip_phase;
    overvolt_comp_out <= trip_comp;
  end
endmodule
`default_nettype wire

/* verif/pwm_fault_protection_control_bench.sv */
// self-checking bench of the pwm fault protection block
// assumes the design, its header, the checker and the front end model
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"
module pwm_fault_protection_control_bench;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        trip_phase = 1'b0;
  logic [6:0]  trip_comp = 7'h00;
  logic        pready, pslverr, err, phase_protect_out, pwm_shutdown;
  logic [6:0]  overvolt_comp_out;
  logic [3:0]  pwm_out;
  logic [7:0]  a;
  logic [31:0] prdata, q, d, dly, seed = 32'd44;
  logic [31:0] dv [5] = '{500, 1024, 1010, 980, 1010};
  int          n_fail = 0;
  int          comparisons = 0;
  int          h0, h1;
  pwm_fault_protection_control dut_u
  (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
    .phase_protect_out(phase_protect_out), .pwm_shutdown(pwm_shutdown),
    .overvolt_comp_out(overvolt_comp_out)
  );
  pwm_power_stage stage_u
  (
    .clock(clock), .trip_phase(trip_phase), .trip_comp(trip_comp),
    .phase_protect_out(phase_protect_out),
    .overvolt_comp_out(overvolt_comp_out)
  );
  initial
    forever #4 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status bit 5 only clears and bit 7 is read only
  function automatic logic [31:0] mask_of(input logic [7:0] r);
    case (r)
      `OFS_STATUS_SOFT: return 32'h13;
      `OFS_POLARITY: return 32'h3;
      `OFS_PERIOD_HIGH, `OFS_DUTY_HIGH: return 32'hf;
      default: return 32'hff;
    endcase
  endfunction
  // high cycles per period, from the period, duty and dead-time rules
  function automatic int high_a(input int dut, input int dt);
    return (dt < dut) ? dut - dt - 1 : 0;
  endfunction
  function automatic int high_b(input int per, input int dut);
    return per + 1 - dut;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [31:0] v,
                    input logic w = 1'b1);
    @(posedge clock);
    psel <= 1'b1;
    paddr <= r;
    pwrite <= w;
    pwdata <= v;
    @(posedge clock);
    penable <= 1'b1;
    // only pready or the watchdog may end this wait
    do
      @(posedge clock);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] r);
    wr(r, 32'h0, 1'b0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_stop(input int lim);
    for (int n = 0; n < lim && pwm_shutdown !== 1'b1; n++)
      @(posedge clock);
    chk({31'h0, pwm_shutdown}, 32'h1);
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    tick(20000);
    n_fail++;
    stop_test();
  end
  initial
  begin
    do_reset();
    for (int i = 0; i <= 17; i++)
    begin
      rd(8'(4 * i));
      chk(q, 32'h0);
    end
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 30; i++)
    begin
      a = 8'(4 * (rnd() % 10));
      if (a == `OFS_COUNTER_LOW)
        a = `OFS_DEADTIME_LOW;
      d = rnd();
      wr(a, d);
      rd(a);
      chk(q, d & mask_of(a));
    end
    $display("registers done");
    wr(`OFS_DELAY_LIMIT, 32'd1000);
    for (int i = 0; i < 5; i++)
    begin
      wr(`OFS_CONTROL, i > 1 ? 32'h2 : 32'h0);
      wr(`OFS_DELAY, dv[i]);
      if (i < 2 || dv[i] <= 32'd1000)
        dly = dv[i];
      rd(`OFS_DELAY);
      chk(q, dly);
    end
    do_reset();
    wr(`OFS_PERIOD_LOW, 32'd20);
    wr(`OFS_DUTY_LOW, 32'd10);
    wr(`OFS_ERR_ENABLE, 32'h1);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_COUNTER_LOW, 32'hff);
    rd(`OFS_COUNTER_LOW);
    chk({31'h0, q <= 32'd20}, 32'h1);
    trip_phase <= 1'b1;
    wait_stop(5);
    rd(`OFS_STATUS_SOFT);
    chk(q, 32'h80);
    wr(`OFS_ACTION_LO, 32'h55);
    rd(`OFS_ACTION_LO);
    chk(q, 32'h0);
    trip_phase <= 1'b0;
    tick(3);
    rd(`OFS_STATUS_SOFT);
    chk(q, 32'h0);
    wr(`OFS_CONTROL, 32'h0);
    $display("phase stop done");
    wr(`OFS_STATUS_SOFT, 32'h1);
    wr(`OFS_CONTROL, 32'h5);
    tick(3);
    rd(`OFS_STATUS_SOFT);
    chk(q, 32'h1);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_STATUS_SOFT, 32'h11);
    wr(`OFS_CONTROL, 32'h5);
    wait_stop(30);
    rd(`OFS_STATUS_SOFT);
    chk(q, 32'hb1);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_STATUS_SOFT, 32'h31);
    rd(`OFS_STATUS_SOFT);
    chk(q, 32'h31);
    wr(`OFS_STATUS_SOFT, 32'h11);
    rd(`OFS_STATUS_SOFT);
    chk(q, 32'h11);
    $display("soft trigger done");
    wr(`OFS_ACTION_LO, 32'hbe);
    wr(`OFS_ACTION_HI, 32'hbe);
    for (int k = 0; k < 7; k++)
    begin
      trip_comp <= 7'(1 << k);
      wr(`OFS_ERR_ENABLE, rnd() & ~(32'h2 << k));
      rd(`OFS_STATUS_SOFT);
      chk(q & 32'h80, 32'h0);
      wr(`OFS_ERR_ENABLE, 32'h2 << k);
      tick(2);
      rd(`OFS_STATUS_SOFT);
      chk(q & 32'h80, 32'h80);
      trip_comp <= 7'h0;
      tick(3);
    end
    $display("comparators done");
    wr(`OFS_DEADTIME_LOW, 32'd3);
    for (int p = 0; p < 2; p++)
    begin
      wr(`OFS_POLARITY, 3 * p);
      wr(`OFS_CONTROL, 32'h1);
      tick(25);
      h0 = 0;
      h1 = 0;
      // one whole period, from any phase, gives the high times
      repeat (21)
      begin
        @(posedge clock);
        h0 += pwm_out[0];
        h1 += pwm_out[1];
      end
      chk(h0, p ? 21 - high_a(10, 3) : high_a(10, 3));
      chk(h1, p ? 21 - high_b(20, 10) : high_b(20, 10));
      wr(`OFS_CONTROL, 32'h0);
    end
    $display("waveform done");
    wr(`OFS_MIN_PERIOD, 32'd16);
    wr(`OFS_ERR_ENABLE, 32'h1);
    for (int c = 2; c < 4; c++)
    begin
      wr(`OFS_ACTION_LO, c);
      wr(`OFS_CONTROL, 32'h1);
      trip_phase <= 1'b1;
      tick(30);
      chk({31'h0, pwm_shutdown}, 32'h0);
      if (c == 2)
        wait_stop(200);
      else
      begin
        tick(200);
        chk({31'h0, pwm_shutdown}, 32'h0);
      end
      trip_phase <= 1'b0;
      wr(`OFS_CONTROL, 32'h0);
    end
    $display("shrink done");
    stop_test();
  end
endmodule
`default_nettype wire
